// >>> hdl/rpbm_pkg.sv
package rpbm_pkg;
  localparam int RPBM_WORD_W = 36;
  localparam int RPBM_HALF_W = 18;
  localparam int RPBM_LANE_W = 9;
  localparam logic [7:0] RPBM_CFG_OFS = 8'h00;
  localparam logic [7:0] RPBM_STAT_OFS = 8'h04;
  localparam int RPBM_CFG_WM_BIT = 0;
  localparam int RPBM_CFG_SZ_BIT = 1;
  localparam int RPBM_CFG_BO_BIT = 2;
  localparam int RPBM_STAT_SUB_POS = 0;
  localparam int RPBM_STAT_MODE_POS = 2;
  localparam int RPBM_STAT_ACT_POS = 4;
  localparam logic [2:0] RPBM_CFG_RST = 3'h0;
  localparam logic [1:0] RPBM_SUB_RST = 2'h0;
  localparam logic [1:0] RPBM_SUB_WORD_LAST = 2'h1;
  localparam logic [1:0] RPBM_SUB_BYTE_LAST = 2'h3;
  localparam logic [2:0] RPBM_BEATS_WORD = 3'h2;
  localparam logic [2:0] RPBM_BEATS_BYTE = 3'h4;
  typedef enum logic [1:0] {RPBM_MD_LONG, RPBM_MD_WORD, RPBM_MD_BYTE} rpbm_mode_t;
  typedef struct packed {
    logic bo;
    logic sz;
    logic wm;
  } rpbm_cfg_t;
  typedef struct packed {
    logic sel;
    logic rd;
    logic adv;
  } rpbm_pin_t;
endpackage

// >>> hdl/rpbm_matcher.sv
// Behaviour
// - both selects low gives 36-bit mode
// - long mode moves all 36 bits
// - long mode has no per-byte selection
// - long mode ignores byte order select
// - match high, pick low gives 18-bit
// - word mode uses data lines 0-17
// - word little endian: low half first
// - word big endian: high half first
// - word transfer takes two or more cycles
// - each part lands in its own lane
// - sub-counter steps up little, down big
// - both selects high gives 9-bit mode
// - byte mode uses data lines 0-8
// - byte little endian: low byte first
// - byte big endian: high byte first
// - byte transfer takes four or more cycles
// - byte mode floats lines 9-35
//
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rpbm_matcher
  import rpbm_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic port_sel,
  input wire logic port_rd,
  input wire logic count_advance_enable,
  input wire logic [RPBM_WORD_W-1:0] port_dq_in,
  output logic [RPBM_WORD_W-1:0] port_dq_out,
  output logic [RPBM_WORD_W-1:0] port_dq_oe_n,
  input wire logic [RPBM_WORD_W-1:0] mem_rdata,
  output logic [RPBM_WORD_W-1:0] mem_wdata,
  output logic mem_we,
  output logic mem_next
);
  function automatic rpbm_mode_t mode_of(input rpbm_cfg_t c);
    if (!c.wm) begin
      mode_of = RPBM_MD_LONG;
    end else if (c.sz) begin
      mode_of = RPBM_MD_BYTE;
    end else begin
      mode_of = RPBM_MD_WORD;
    end
  endfunction

  function automatic logic [1:0] sub_last(input rpbm_mode_t m);
    case (m)
      RPBM_MD_WORD: sub_last = RPBM_SUB_WORD_LAST;
      RPBM_MD_BYTE: sub_last = RPBM_SUB_BYTE_LAST;
      default: sub_last = RPBM_SUB_RST;
    endcase
  endfunction

  function automatic logic [RPBM_WORD_W-1:0] lane_get(input logic [RPBM_WORD_W-1:0] w,
      input rpbm_mode_t m, input logic [1:0] s);
    lane_get = w;
    case (m)
      RPBM_MD_WORD: lane_get = {18'h0, w[RPBM_HALF_W*s[0] +: RPBM_HALF_W]};
      RPBM_MD_BYTE: lane_get = {27'h0, w[RPBM_LANE_W*s +: RPBM_LANE_W]};
      default: lane_get = w;
    endcase
  endfunction

  function automatic logic [RPBM_WORD_W-1:0] lane_put(input logic [RPBM_WORD_W-1:0] w,
      input rpbm_mode_t m, input logic [1:0] s, input logic [RPBM_WORD_W-1:0] d);
    lane_put = w;
    case (m)
      RPBM_MD_WORD: lane_put[RPBM_HALF_W*s[0] +: RPBM_HALF_W] = d[RPBM_HALF_W-1:0];
      RPBM_MD_BYTE: lane_put[RPBM_LANE_W*s +: RPBM_LANE_W] = d[RPBM_LANE_W-1:0];
      default: lane_put = d;
    endcase
  endfunction

  // Pins come from the far side of the board, so both stages are kept apart.
  rpbm_pin_t pin_m_q, pin_q;
  logic [RPBM_WORD_W-1:0] din_m_q, din_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_m_q <= '0;
      pin_q <= '0;
      din_m_q <= '0;
      din_q <= '0;
    end else begin
      pin_m_q <= {port_sel, port_rd, count_advance_enable};
      pin_q <= pin_m_q;
      din_m_q <= port_dq_in;
      din_q <= din_m_q;
    end
  end

  rpbm_cfg_t cfg_q, cfg_d, act_q, act_d;
  logic wr_pend_q, wr_pend_d, ap;
  logic [7:0] wr_ofs_q, wr_ofs_d;
  logic [31:0] hrdata_d;
  logic [1:0] sub_q, sub_d, sub_start, sub_end;
  rpbm_mode_t mode_q, mode_d;
  logic [RPBM_WORD_W-1:0] dout_d, oe_n_d, wbuf_q, wbuf_d, mwd_d;
  logic we_d, next_d;
  logic [2:0] wbeats_q, wbeats_d;

  always_comb begin
    ap = hsel && htrans[1] && hready;
    wr_pend_d = ap && hwrite;
    wr_ofs_d = ap ? haddr[7:0] : wr_ofs_q;
    cfg_d = cfg_q;
    if (wr_pend_q && wr_ofs_q == RPBM_CFG_OFS) begin
      cfg_d = rpbm_cfg_t'(hwdata[2:0]);
    end
    hrdata_d = 32'h0;
    if (ap && !hwrite) begin
      if (haddr[7:0] == RPBM_CFG_OFS) begin
        hrdata_d[2:0] = cfg_q;
      end else if (haddr[7:0] == RPBM_STAT_OFS) begin
        hrdata_d[RPBM_STAT_SUB_POS +: 2] = sub_q;
        hrdata_d[RPBM_STAT_MODE_POS +: 2] = mode_q;
        hrdata_d[RPBM_STAT_ACT_POS +: 3] = act_q;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_ofs_q <= 8'h00;
      cfg_q <= rpbm_cfg_t'(RPBM_CFG_RST);
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_ofs_q <= wr_ofs_d;
      cfg_q <= cfg_d;
      hrdata <= hrdata_d;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_comb begin
    sub_start = act_q.bo ? sub_last(mode_q) : RPBM_SUB_RST;
    sub_end = act_q.bo ? RPBM_SUB_RST : sub_last(mode_q);
    act_d = act_q;
    mode_d = mode_q;
    sub_d = sub_q;
    wbuf_d = wbuf_q;
    mwd_d = mem_wdata;
    we_d = 1'b0;
    next_d = 1'b0;
    dout_d = '0;
    oe_n_d = '1;
    wbeats_d = wbeats_q;
    // A new setting takes hold one cycle after its write and restarts the word.
    if (cfg_q != act_q) begin
      act_d = cfg_q;
      mode_d = mode_of(cfg_q);
      sub_d = (cfg_q.bo && cfg_q.wm) ? sub_last(mode_of(cfg_q)) : RPBM_SUB_RST;
      wbeats_d = 3'h0;
    end else if (pin_q.sel) begin
      if (mode_q == RPBM_MD_LONG) begin
        if (pin_q.rd) begin
          dout_d = mem_rdata;
          oe_n_d = '0;
        end else begin
          mwd_d = din_q;
          we_d = 1'b1;
        end
        next_d = pin_q.adv;
      end else begin
        if (pin_q.rd) begin
          dout_d = lane_get(mem_rdata, mode_q, sub_q);
          oe_n_d = (mode_q == RPBM_MD_BYTE) ? {27'h7ffffff, 9'h0}
              : {18'h3ffff, 18'h0};
        end else begin
          wbuf_d = lane_put(wbuf_q, mode_q, sub_q, din_q);
          wbeats_d = wbeats_q + 3'h1;
        end
        // Without count advance the sub-counter parks and the word never completes.
        if (pin_q.adv) begin
          if (sub_q == sub_end) begin
            sub_d = sub_start;
            next_d = 1'b1;
            if (!pin_q.rd) begin
              mwd_d = wbuf_d;
              we_d = 1'b1;
            end
          end else begin
            sub_d = act_q.bo ? sub_q - 2'h1 : sub_q + 2'h1;
          end
        end
      end
    end
    if (mem_we) begin
      wbeats_d = (pin_q.sel && !pin_q.rd && mode_q != RPBM_MD_LONG && cfg_q == act_q)
          ? 3'h1 : 3'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_q <= rpbm_cfg_t'(RPBM_CFG_RST);
      mode_q <= RPBM_MD_LONG;
      sub_q <= RPBM_SUB_RST;
      wbuf_q <= '0;
      mem_wdata <= '0;
      mem_we <= 1'b0;
      mem_next <= 1'b0;
      port_dq_out <= '0;
      port_dq_oe_n <= '1;
      wbeats_q <= 3'h0;
    end else begin
      act_q <= act_d;
      mode_q <= mode_d;
      sub_q <= sub_d;
      wbuf_q <= wbuf_d;
      mem_wdata <= mwd_d;
      mem_we <= we_d;
      mem_next <= next_d;
      port_dq_out <= dout_d;
      port_dq_oe_n <= oe_n_d;
      wbeats_q <= wbeats_d;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic stable, beat;
  assign stable = cfg_q == act_q;
  assign beat = stable && pin_q.sel;

  a_byte_float: assert property (mode_q == RPBM_MD_BYTE |=> &port_dq_oe_n[35:9])
    else $error("byte mode drove an unused lane");
  a_word_float: assert property (mode_q == RPBM_MD_WORD |=> &port_dq_oe_n[35:18])
    else $error("word mode drove an unused lane");
  a_long_write: assert property (beat && mode_q == RPBM_MD_LONG && !pin_q.rd
      |=> mem_we && mem_wdata == $past(din_q))
    else $error("long write did not pass the whole word");
  a_long_order: assert property (beat && mode_q == RPBM_MD_LONG |=> sub_q == 2'h0)
    else $error("long mode moved the sub-counter");
  a_sub_up: assert property (beat && pin_q.adv && mode_q != RPBM_MD_LONG && !act_q.bo
      && sub_q != sub_end |=> sub_q == $past(sub_q) + 2'h1)
    else $error("little endian step wrong");
  a_sub_down: assert property (beat && pin_q.adv && mode_q != RPBM_MD_LONG && act_q.bo
      && sub_q != sub_end |=> sub_q == $past(sub_q) - 2'h1)
    else $error("big endian step wrong");
  a_first_lane: assert property (!stable ##1 stable
      |-> sub_q == ((act_q.bo && act_q.wm) ? sub_last(mode_q) : 2'h0))
    else $error("wrong first lane after setup");
  a_byte_read: assert property (beat && pin_q.rd && mode_q == RPBM_MD_BYTE
      |=> port_dq_out[8:0] == $past(mem_rdata[9*sub_q +: 9]) && !port_dq_oe_n[0])
    else $error("byte read lane wrong");
  a_lane_place: assert property (beat && !pin_q.rd && mode_q == RPBM_MD_WORD
      |=> wbuf_q[18*$past(sub_q[0]) +: 18] == $past(din_q[17:0]))
    else $error("half word stored in wrong lane");
  a_byte_four: assert property (mem_we && mode_q == RPBM_MD_BYTE && $stable(act_q)
      |-> wbeats_q == RPBM_BEATS_BYTE)
    else $error("byte word written in fewer than four beats");
  a_word_two: assert property (mem_we && mode_q == RPBM_MD_WORD && $stable(act_q)
      |-> wbeats_q == RPBM_BEATS_WORD)
    else $error("half words written in wrong count");
  a_long_read: assert property (beat && pin_q.rd && mode_q == RPBM_MD_LONG
      |=> port_dq_out == $past(mem_rdata) && port_dq_oe_n == '0)
    else $error("long read did not drive the whole word");
  a_word_read: assert property (beat && pin_q.rd && mode_q == RPBM_MD_WORD
      |=> port_dq_out == {18'h0, $past(mem_rdata[18*sub_q[0] +: 18])}
      && port_dq_oe_n == {18'h3ffff, 18'h0})
    else $error("word read lane wrong");
  a_byte_store: assert property (beat && !pin_q.rd && mode_q == RPBM_MD_BYTE
      |=> wbuf_q[9*$past(sub_q) +: 9] == $past(din_q[8:0]))
    else $error("byte stored in wrong lane");
  a_long_mode: assert property (!stable && !cfg_q.wm
      |=> mode_q == RPBM_MD_LONG)
    else $error("long mode not selected");
  a_word_mode: assert property (!stable && cfg_q.wm && !cfg_q.sz
      |=> mode_q == RPBM_MD_WORD)
    else $error("word mode not selected");
  a_byte_mode: assert property (!stable && cfg_q.wm && cfg_q.sz
      |=> mode_q == RPBM_MD_BYTE)
    else $error("byte mode not selected");
  a_narrow_wrap: assert property (beat && pin_q.adv && mode_q != RPBM_MD_LONG
      && sub_q == sub_end |=> sub_q == $past(sub_start) && mem_next)
    else $error("narrow word did not wrap at its last part");
  a_long_next: assert property (beat && mode_q == RPBM_MD_LONG
      |=> mem_next == $past(pin_q.adv))
    else $error("long beat address step wrong");
endmodule
`default_nettype wire

// >>> verification/rpbm_port_master.sv
`timescale 1ns/1ps
`default_nettype none
module rpbm_port_master
  import rpbm_pkg::*;
(
  input wire logic hclk,
  output logic port_sel,
  output logic port_rd,
  output logic count_advance_enable,
  output logic [RPBM_WORD_W-1:0] port_dq_in
);
  // The counter starts in increment mode so the sub-counter can step the lanes.
  initial begin
    port_sel = 1'b0;
    port_rd = 1'b0;
    count_advance_enable = 1'b1;
    port_dq_in = '0;
  end
  // One part per cycle, so a narrow word spans as many cycles as it has parts.
  task automatic beat(input logic rd, input logic [RPBM_WORD_W-1:0] d);
    @(posedge hclk);
    port_sel <= 1'b1;
    port_rd <= rd;
    port_dq_in <= d;
  endtask
  task automatic advance(input logic a);
    @(posedge hclk);
    count_advance_enable <= a;
  endtask
  // Released lines toggle so stale data is never mistaken for a fresh part.
  task automatic idle;
    @(posedge hclk);
    port_sel <= 1'b0;
    port_dq_in <= ~port_dq_in;
  endtask
endmodule
`default_nettype wire

// >>> verification/test_right_port_bus_width_matcher.sv
`timescale 1ns/1ps
`default_nettype none
module test_right_port_bus_width_matcher;
  import rpbm_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0;
  logic port_sel, port_rd, count_advance_enable, mem_we, mem_next;
  logic [35:0] port_dq_in, port_dq_out, port_dq_oe_n, mem_rdata = 0, mem_wdata;
  logic [71:0] rq[$];
  logic [35:0] wq[$];
  logic [2:0] cl[7] = '{3'h0, 3'h4, 3'h2, 3'h1, 3'h5, 3'h3, 3'h7};
  int n_mismatch = 0, total_checks = 0;
  int nn = 0;
  always #4 hclk = ~hclk;
  rpbm_matcher dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .port_sel(port_sel),
    .port_rd(port_rd), .count_advance_enable(count_advance_enable),
    .port_dq_in(port_dq_in), .port_dq_out(port_dq_out), .port_dq_oe_n(port_dq_oe_n),
    .mem_rdata(mem_rdata), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_next(mem_next));
  rpbm_port_master pm (.hclk(hclk), .port_sel(port_sel), .port_rd(port_rd),
    .count_advance_enable(count_advance_enable), .port_dq_in(port_dq_in));
  always @(posedge hclk) begin
    if (port_dq_oe_n !== '1) rq.push_back({port_dq_oe_n, port_dq_out});
    if (mem_we === 1'b1) wq.push_back(mem_wdata);
    if (mem_next === 1'b1) nn++;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 16);
    if (hreadyout !== 1'b1) begin
      n_mismatch++;
      finish_test();
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
    chk(hresp, 1'b0);
  endtask
  function automatic int np(input logic [2:0] c);
    np = c[0] ? (c[1] ? 4 : 2) : 1;
  endfunction
  // Part i of word w as it crosses the port, or the mask of the lines it leaves unused when oe is set.
  function automatic logic [35:0] part(input logic [2:0] c, input logic [35:0] w,
                                       input int i, input logic oe);
    int n, wd, l;
    logic [35:0] m;
    n = np(c);
    wd = 36 / n;
    l = (c[2] && n > 1) ? n - 1 - i : i;
    m = (36'h1 << wd) - 36'h1;
    part = oe ? ~m : (w >> (l * wd)) & m;
  endfunction
  function automatic logic [35:0] rnd;
    rnd = 36'({$urandom(), $urandom()});
  endfunction
  initial begin
    logic [2:0] c;
    logic [31:0] q;
    logic [35:0] w, r;
    int n;
    void'($urandom(47958));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (cl[j]) begin
      c = cl[j];
      n = np(c);
      ahb(1'b1, 8'h00, {29'h0, c}, q);
      repeat (4) pm.idle(); // Selects settle ahead of use.
      ahb(1'b0, 8'h00, 32'h0, q);
      chk(q, c);
      ahb(1'b0, 8'h04, 32'h0, q);
      chk(q[3:2], n >> 1);
      for (int k = 0; k < 3; k++) begin
        w = k ? rnd() : '1;
        r = rnd();
        wq.delete();
        nn = 0;
        rq.delete();
        for (int i = 0; i < n; i++) begin
          pm.beat(1'b0, part(c, w, i, 0) | (rnd() & part(c, w, i, 1)));
          if (k == 2) pm.idle();
        end
        repeat (6) pm.idle();
        chk(wq.size(), 1);
        chk(rq.size(), 0);
        if (wq.size() == 1) chk(wq[0], w);
        chk(nn, 1);
        nn = 0;
        mem_rdata <= r;
        for (int i = 0; i < n; i++) begin
          pm.beat(1'b1, rnd());
          if (k == 2) pm.idle();
        end
        repeat (6) pm.idle();
        chk(rq.size(), n);
        chk(nn, 1);
        foreach (rq[i]) chk(rq[i], {part(c, r, i, 1), part(c, r, i, 0)});
      end
      pm.advance(1'b0);
      repeat (3) pm.idle();
      wq.delete();
      nn = 0;
      repeat (2) pm.beat(1'b0, rnd());
      repeat (6) pm.idle();
      chk(wq.size(), n == 1 ? 2 : 0);
      chk(nn, 0);
      pm.advance(1'b1);
      $display("cfg %h done", c);
    end
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    chk({hrdata, port_dq_oe_n, mem_we}, {32'h0, 36'hfffffffff, 1'b0});
    hresetn <= 1'b1;
    ahb(1'b0, 8'h00, 32'h0, q);
    chk(q, 0);
    ahb(1'b0, 8'h04, 32'h0, q);
    chk(q, 0);
    $display("reset done");
    ahb(1'b0, 8'h08, 32'h0, q);
    chk(q, 0);
    finish_test();
  end
endmodule
`default_nettype wire
